// ==== rtl/lsa_pkg.sv ====
// Constants shared by the light sensor converter control block.
// Assumes a single top module that reads every name through lsa_pkg::.
`default_nettype none
package lsa_pkg;

  // Fixed seven-bit bus address, binary 1000100.
  localparam logic [6:0]  SLAVE_ADDR        = 7'h44;

  // Register offsets, taken from the low three bits of the register address.
  localparam logic [2:0]  OFS_COMMAND       = 3'h0;
  localparam logic [2:0]  OFS_CONTROL       = 3'h1;
  localparam logic [2:0]  OFS_UPPER_THR     = 3'h2;
  localparam logic [2:0]  OFS_LOWER_THR     = 3'h3;
  localparam logic [2:0]  OFS_RESULT_LO     = 3'h4;
  localparam logic [2:0]  OFS_RESULT_HI     = 3'h5;
  localparam logic [2:0]  OFS_COUNT_LO      = 3'h6;
  localparam logic [2:0]  OFS_COUNT_HI      = 3'h7;

  // Register address strobe bits.
  localparam int          ADDR_RESTART_BIT  = 7;
  localparam int          ADDR_CLEAR_BIT    = 6;

  // Field positions of the command register.
  localparam int          CMD_ENABLE_BIT    = 7;
  localparam int          CMD_POWER_BIT     = 6;
  localparam int          CMD_EXTERNAL_BIT  = 5;
  localparam int          CMD_MODE_LSB      = 2;
  localparam int          CMD_WIDTH_LSB     = 0;
  localparam logic [7:0]  CMD_WRITE_MASK    = 8'hEF;

  // Field positions of the control register.
  localparam int          CTL_FLAG_BIT      = 5;
  localparam int          CTL_GAIN_LSB      = 2;
  localparam int          CTL_PERSIST_LSB   = 0;
  localparam logic [7:0]  CTL_WRITE_MASK    = 8'hDF;

  // Reset values.
  localparam logic [7:0]  COMMAND_RESET     = 8'h00;
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  localparam logic [7:0]  UPPER_THR_RESET   = 8'hFF;
  localparam logic [7:0]  LOWER_THR_RESET   = 8'h00;
  localparam logic [7:0]  THR_LOW_BYTE      = 8'h00;

  // Conversion source codes.
  localparam logic [1:0]  MODE_BROADBAND    = 2'h0;
  localparam logic [1:0]  MODE_INFRARED     = 2'h1;
  localparam logic [1:0]  MODE_DIFFERENCE   = 2'h2;
  localparam logic [1:0]  MODE_NONE         = 2'h3;

  // Cycle exponents for width codes 3..0 and persistence counts for codes 3..0, five bits each.
  localparam logic [19:0] WIDTH_EXP_TABLE   = {5'h04, 5'h08, 5'h0C, 5'h10};
  localparam logic [19:0] PERSIST_TABLE     = {5'h10, 5'h08, 5'h04, 5'h01};

  // Limits of the signed 15-bit difference result.
  localparam logic [16:0] DIFF_MAX          = 17'h03FFF;
  localparam logic [16:0] DIFF_MIN          = 17'h1C000;
  localparam logic [15:0] COUNT_SAT         = 16'hFFFF;

  typedef enum logic [8:0] {
    SI_IDLE = 9'h001,
    SI_ADDR = 9'h002,
    SI_AACK = 9'h004,
    SI_REG  = 9'h008,
    SI_RACK = 9'h010,
    SI_WR   = 9'h020,
    SI_WACK = 9'h040,
    SI_RD   = 9'h080,
    SI_DACK = 9'h100
  } lsa_bus_state_t;

  typedef enum logic [3:0] {
    OS_IDLE = 4'h1,
    OS_WAIT = 4'h2,
    OS_A    = 4'h4,
    OS_B    = 4'h8
  } lsa_conv_state_t;

endpackage : lsa_pkg
`default_nettype wire

// ==== rtl/lsa_top.sv ====
// Light sensor converter control: two-wire slave, registers, integration timing and alarm.
// Assumes i_clk at 250 MHz, i_osc_clk is the converter oscillator unrelated in phase,
// and the charge-balance pulse inputs are produced on i_osc_clk.
//
// What this block does
// - Command bits 3:2 pick broadband, infrared or signed 15-bit difference; 3 idles.
// - Difference mode integrates broadband then infrared and subtracts the second.
// - Command bits 1:0 set 2^16, 2^12, 2^8 or 2^4 cycles per integration.
// - Internal timing counts the integration period on the oscillator clock.
// - External timing integrates exactly between two consecutive restart accesses.
// - Command bit 5 selects internal (0) or host-synchronised (1) timing.
// - Command bit 7 at 0 holds the converter core in reset; 1 enables it.
// - Command bit 6 at 1 selects power-down, 0 normal operation.
// - Control bit 5 reads the alarm flag: 1 triggered, 0 cleared or idle.
// - Control bits 3:2 select the gain range.
// - Control bits 1:0 set persistence of 1, 4, 8 or 16 integrations.
// - Upper threshold byte register resets to all ones.
// - Lower threshold byte register resets to zero.
// - Active-low open-drain alarm pulls low outside the threshold window.
// - Offsets 04 and 05 read the result bytes; writes are ignored.
// - Offsets 06 and 07 read the cycle count of the latest integration.
// - Command and control registers hold until the host rewrites them.
// - Slave answers address 1000100; eighth bit is read or write.
// - Register address bit 7 in external mode ends and restarts integration.
// - Register address bit 6 clears the alarm pin and flag.
// - Alarm asserts only after the set number of consecutive out-of-window results.
// - Each threshold byte is the high byte of a 16-bit value, low byte zero.
// - Result registers refresh at the end of every completed integration except the broadband one in difference mode.
`timescale 1ns/1ps
`default_nettype none

module lsa_top (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc_clk,
  input  wire logic       i_scl,
  input  wire logic       i_sda_i,
  input  wire logic       i_broadband_pulse,
  input  wire logic       i_infrared_pulse,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  output logic            o_alarm_n_o,
  output logic            o_alarm_n_oe,
  output logic            o_adc_core_reset,
  output logic            o_power_down,
  output logic            o_diode_select,
  output logic            o_osc_fast,
  output logic [1:0]      o_gain
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus pin sampling on the system clock.

  logic [2:0]             scl_sync_reg;
  logic [2:0]             sda_sync_reg;
  logic                   scl_reg;
  logic                   sda_reg;
  logic                   scl_prev_reg;
  logic                   sda_prev_reg;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   bus_start;
  logic                   bus_stop;

  // A level is taken only when the second and third stages agree, which also rejects short glitches.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda_i};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  assign scl_rise  = scl_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_reg & scl_prev_reg;
  assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  assign bus_stop  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Two-wire slave.

  lsa_pkg::lsa_bus_state_t bus_state_reg;
  logic [3:0]             bit_cnt_reg;
  logic [7:0]             shift_reg;
  logic [7:0]             tx_reg;
  logic [7:0]             ptr_reg;
  logic                   rw_reg;
  logic                   nack_reg;
  logic                   sda_oe_reg;
  logic                   wr_stb_reg;
  logic                   ptr_stb_reg;
  logic [7:0]             rd_data;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus_state_reg <= lsa_pkg::SI_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      ptr_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      nack_reg      <= 1'b0;
      sda_oe_reg    <= 1'b0;
      wr_stb_reg    <= 1'b0;
      ptr_stb_reg   <= 1'b0;
    end else begin
      wr_stb_reg  <= 1'b0;
      ptr_stb_reg <= 1'b0;
      if (bus_stop) begin
        bus_state_reg <= lsa_pkg::SI_IDLE;
        sda_oe_reg    <= 1'b0;
      end else if (bus_start) begin
        bus_state_reg <= lsa_pkg::SI_ADDR;
        bit_cnt_reg   <= 4'h0;
        sda_oe_reg    <= 1'b0;
      end else if (scl_rise) begin
        if (bus_state_reg == lsa_pkg::SI_ADDR || bus_state_reg == lsa_pkg::SI_REG ||
            bus_state_reg == lsa_pkg::SI_WR) begin
          shift_reg   <= {shift_reg[6:0], sda_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (bus_state_reg == lsa_pkg::SI_RD) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (bus_state_reg == lsa_pkg::SI_DACK) begin
          nack_reg <= sda_reg;
        end
      end else if (scl_fall) begin
        unique case (bus_state_reg)
          lsa_pkg::SI_IDLE: begin
          end
          lsa_pkg::SI_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == lsa_pkg::SLAVE_ADDR) begin
                bus_state_reg <= lsa_pkg::SI_AACK;
                rw_reg        <= shift_reg[0];
                sda_oe_reg    <= 1'b1;
              end else begin
                bus_state_reg <= lsa_pkg::SI_IDLE;
              end
            end
          end
          lsa_pkg::SI_AACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              bus_state_reg <= lsa_pkg::SI_RD;
              tx_reg        <= rd_data;
              sda_oe_reg    <= ~rd_data[7];
            end else begin
              bus_state_reg <= lsa_pkg::SI_REG;
              sda_oe_reg    <= 1'b0;
            end
          end
          lsa_pkg::SI_REG: begin
            if (bit_cnt_reg == 4'h8) begin
              bus_state_reg <= lsa_pkg::SI_RACK;
              ptr_reg       <= shift_reg;
              ptr_stb_reg   <= 1'b1;
              sda_oe_reg    <= 1'b1;
            end
          end
          lsa_pkg::SI_RACK, lsa_pkg::SI_WACK: begin
            bus_state_reg <= lsa_pkg::SI_WR;
            bit_cnt_reg   <= 4'h0;
            sda_oe_reg    <= 1'b0;
          end
          lsa_pkg::SI_WR: begin
            if (bit_cnt_reg == 4'h8) begin
              bus_state_reg <= lsa_pkg::SI_WACK;
              wr_stb_reg    <= 1'b1;
              sda_oe_reg    <= 1'b1;
            end
          end
          lsa_pkg::SI_RD: begin
            if (bit_cnt_reg == 4'h8) begin
              bus_state_reg <= lsa_pkg::SI_DACK;
              sda_oe_reg    <= 1'b0;
            end else begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
          lsa_pkg::SI_DACK: begin
            bit_cnt_reg <= 4'h0;
            if (nack_reg) begin
              bus_state_reg <= lsa_pkg::SI_IDLE;
            end else begin
              bus_state_reg <= lsa_pkg::SI_RD;
              tx_reg        <= rd_data;
              sda_oe_reg    <= ~rd_data[7];
            end
          end
        endcase
      end
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0]             command_reg;
  logic [7:0]             control_reg;
  logic [7:0]             upper_thr_reg;
  logic [7:0]             lower_thr_reg;
  logic [15:0]            result_reg;
  logic [15:0]            count_reg;
  logic                   flag_reg;
  logic                   restart_tgl_reg;
  logic                   clear_stb_reg;
  logic                   ptr_mapped;

  assign ptr_mapped = (ptr_reg[5:3] == 3'h0);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      command_reg   <= lsa_pkg::COMMAND_RESET;
      control_reg   <= lsa_pkg::CONTROL_RESET;
      upper_thr_reg <= lsa_pkg::UPPER_THR_RESET;
      lower_thr_reg <= lsa_pkg::LOWER_THR_RESET;
    end else if (wr_stb_reg && ptr_mapped) begin
      unique case (ptr_reg[2:0])
        lsa_pkg::OFS_COMMAND:   command_reg   <= shift_reg & lsa_pkg::CMD_WRITE_MASK;
        lsa_pkg::OFS_CONTROL:   control_reg   <= shift_reg & lsa_pkg::CTL_WRITE_MASK;
        lsa_pkg::OFS_UPPER_THR: upper_thr_reg <= shift_reg;
        lsa_pkg::OFS_LOWER_THR: lower_thr_reg <= shift_reg;
        default: begin
        end
      endcase
    end
  end

  // The restart request crosses as a toggle so that back-to-back requests are never merged.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      restart_tgl_reg <= 1'b0;
      clear_stb_reg   <= 1'b0;
    end else begin
      clear_stb_reg <= ptr_stb_reg & shift_reg[lsa_pkg::ADDR_CLEAR_BIT];
      if (ptr_stb_reg && shift_reg[lsa_pkg::ADDR_RESTART_BIT] &&
          command_reg[lsa_pkg::CMD_EXTERNAL_BIT]) begin
        restart_tgl_reg <= ~restart_tgl_reg;
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (ptr_mapped) begin
      unique case (ptr_reg[2:0])
        lsa_pkg::OFS_COMMAND:   rd_data = command_reg;
        lsa_pkg::OFS_CONTROL:   rd_data = control_reg | {2'h0, flag_reg, 5'h00};
        lsa_pkg::OFS_UPPER_THR: rd_data = upper_thr_reg;
        lsa_pkg::OFS_LOWER_THR: rd_data = lower_thr_reg;
        lsa_pkg::OFS_RESULT_LO: rd_data = result_reg[7:0];
        lsa_pkg::OFS_RESULT_HI: rd_data = result_reg[15:8];
        lsa_pkg::OFS_COUNT_LO:  rd_data = count_reg[7:0];
        lsa_pkg::OFS_COUNT_HI:  rd_data = count_reg[15:8];
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_adc_core_reset <= 1'b1;
      o_power_down     <= 1'b0;
      o_gain           <= 2'h0;
      o_osc_fast       <= 1'b0;
    end else begin
      o_adc_core_reset <= ~command_reg[lsa_pkg::CMD_ENABLE_BIT];
      o_power_down     <= command_reg[lsa_pkg::CMD_POWER_BIT];
      o_gain           <= control_reg[lsa_pkg::CTL_GAIN_LSB +: 2];
      o_osc_fast       <= control_reg[lsa_pkg::CTL_GAIN_LSB + 1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Settings into the oscillator domain.

  localparam int          CFG_W = 8;
  logic [CFG_W-1:0]       cfg_src;
  logic [CFG_W-1:0]       cfg_s1_reg;
  logic [CFG_W-1:0]       cfg_s2_reg;
  logic [CFG_W-1:0]       cfg_s3_reg;
  logic [CFG_W-1:0]       cfg_reg;
  logic [2:0]             orst_sync_reg;
  logic                   orst_n;

  assign cfg_src = {restart_tgl_reg, command_reg[7:5], command_reg[3:0]};
  assign orst_n  = orst_sync_reg[2];

  always_ff @(posedge i_osc_clk) begin
    orst_sync_reg <= {orst_sync_reg[1:0], i_rst_n};
    cfg_s1_reg    <= cfg_src;
    cfg_s2_reg    <= cfg_s1_reg;
    cfg_s3_reg    <= cfg_s2_reg;
  end

  // Each bit is taken once stable; the settings are quasi-static, so a one-cycle skew between bits is harmless.
  for (genvar gi = 0; gi < CFG_W; gi++) begin : g_cfg
    always_ff @(posedge i_osc_clk) begin
      if (!orst_n) begin
        cfg_reg[gi] <= 1'b0;
      end else if (cfg_s2_reg[gi] == cfg_s3_reg[gi]) begin
        cfg_reg[gi] <= cfg_s3_reg[gi];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Integration sequencer on the oscillator clock.

  lsa_pkg::lsa_conv_state_t conv_state_reg;
  logic                   restart_seen_reg;
  logic                   restart_ev;
  logic                   conv_run;
  logic                   conv_ext;
  logic [1:0]             conv_mode;
  logic [4:0]             conv_exp;
  logic [16:0]            period_last;
  logic [15:0]            acc_max;
  logic [16:0]            cyc_reg;
  logic [16:0]            cyc_inc;
  logic [15:0]            acc_reg;
  logic [15:0]            first_reg;
  logic [16:0]            diff;
  logic                   phase_end;
  logic                   pulse_sel;
  logic [15:0]            res_hold_reg;
  logic [15:0]            cnt_hold_reg;
  logic                   pub_tgl_reg;

  assign conv_ext    = cfg_reg[4];
  assign conv_mode   = cfg_reg[3:2];
  assign conv_run    = cfg_reg[6] & ~cfg_reg[5] & (conv_mode != lsa_pkg::MODE_NONE);
  assign conv_exp    = lsa_pkg::WIDTH_EXP_TABLE[5 * cfg_reg[1:0] +: 5];
  assign period_last = (17'h00001 << conv_exp) - 17'h00001;
  assign acc_max     = period_last[15:0];
  assign restart_ev  = cfg_reg[7] ^ restart_seen_reg;
  assign phase_end   = conv_ext ? restart_ev : (cyc_reg == period_last);
  assign cyc_inc     = (cyc_reg == 17'h1FFFF) ? cyc_reg : cyc_reg + 17'h00001;
  assign diff        = {1'b0, first_reg} - {1'b0, acc_reg};
  assign pulse_sel   = o_diode_select ? i_infrared_pulse : i_broadband_pulse;

  always_ff @(posedge i_osc_clk) begin
    if (!orst_n) begin
      restart_seen_reg <= 1'b0;
    end else begin
      restart_seen_reg <= cfg_reg[7];
    end
  end

  always_ff @(posedge i_osc_clk) begin
    if (!orst_n) begin
      conv_state_reg <= lsa_pkg::OS_IDLE;
      cyc_reg        <= 17'h00000;
      acc_reg        <= 16'h0000;
      first_reg      <= 16'h0000;
      res_hold_reg   <= 16'h0000;
      cnt_hold_reg   <= 16'h0000;
      pub_tgl_reg    <= 1'b0;
      o_diode_select <= 1'b0;
    end else if (!conv_run) begin
      conv_state_reg <= lsa_pkg::OS_IDLE;
      cyc_reg        <= 17'h00000;
      acc_reg        <= 16'h0000;
      o_diode_select <= 1'b0;
    end else begin
      unique case (conv_state_reg)
        lsa_pkg::OS_IDLE: begin
          conv_state_reg <= conv_ext ? lsa_pkg::OS_WAIT : lsa_pkg::OS_A;
          o_diode_select <= (conv_mode == lsa_pkg::MODE_INFRARED);
          cyc_reg        <= 17'h00000;
          acc_reg        <= 16'h0000;
        end
        lsa_pkg::OS_WAIT: begin
          if (restart_ev) begin
            conv_state_reg <= lsa_pkg::OS_A;
          end
        end
        lsa_pkg::OS_A, lsa_pkg::OS_B: begin
          if (phase_end) begin
            cyc_reg <= 17'h00000;
            acc_reg <= 16'h0000;
            if (conv_state_reg == lsa_pkg::OS_A && conv_mode == lsa_pkg::MODE_DIFFERENCE) begin
              conv_state_reg <= lsa_pkg::OS_B;
              first_reg      <= acc_reg;
              o_diode_select <= 1'b1;
            end else begin
              conv_state_reg <= lsa_pkg::OS_A;
              o_diode_select <= (conv_mode == lsa_pkg::MODE_INFRARED);
              pub_tgl_reg    <= ~pub_tgl_reg;
              cnt_hold_reg   <= cyc_inc[16] ? lsa_pkg::COUNT_SAT : cyc_inc[15:0];
              if (conv_mode != lsa_pkg::MODE_DIFFERENCE) begin
                res_hold_reg <= acc_reg;
              end else if (!diff[16] && diff > lsa_pkg::DIFF_MAX) begin
                res_hold_reg <= lsa_pkg::DIFF_MAX[15:0];
              end else if (diff[16] && diff < lsa_pkg::DIFF_MIN) begin
                res_hold_reg <= lsa_pkg::DIFF_MIN[15:0];
              end else begin
                res_hold_reg <= diff[15:0];
              end
            end
          end else begin
            cyc_reg <= cyc_inc;
            if (pulse_sel && acc_reg != acc_max) begin
              acc_reg <= acc_reg + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Results back into the system domain and the alarm.

  logic [2:0]             pub_sync_reg;
  logic                   pub_lvl_reg;
  logic                   pub_seen_reg;
  logic                   new_result;
  logic [4:0]             persist_cnt_reg;
  logic [4:0]             persist_need;
  logic                   out_window;
  logic                   trigger;

  // Held words are read only after the toggle settles; they stay still for at least 16 oscillator cycles.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pub_sync_reg <= 3'h0;
      pub_lvl_reg  <= 1'b0;
      pub_seen_reg <= 1'b0;
      result_reg   <= 16'h0000;
      count_reg    <= 16'h0000;
    end else begin
      pub_sync_reg <= {pub_sync_reg[1:0], pub_tgl_reg};
      if (pub_sync_reg[1] == pub_sync_reg[2]) begin
        pub_lvl_reg <= pub_sync_reg[2];
      end
      pub_seen_reg <= pub_lvl_reg;
      if (new_result) begin
        result_reg <= res_hold_reg;
        count_reg  <= cnt_hold_reg;
      end
    end
  end

  assign new_result   = pub_lvl_reg ^ pub_seen_reg;
  assign persist_need = lsa_pkg::PERSIST_TABLE[5 * control_reg[lsa_pkg::CTL_PERSIST_LSB +: 2] +: 5];
  assign out_window   = (res_hold_reg > {upper_thr_reg, lsa_pkg::THR_LOW_BYTE}) ||
                        (res_hold_reg < {lower_thr_reg, lsa_pkg::THR_LOW_BYTE});
  assign trigger      = new_result & out_window & command_reg[lsa_pkg::CMD_ENABLE_BIT] &
                        ((persist_cnt_reg + 5'h01) >= persist_need);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !command_reg[lsa_pkg::CMD_ENABLE_BIT]) begin
      persist_cnt_reg <= 5'h00;
    end else if (new_result) begin
      if (!out_window) begin
        persist_cnt_reg <= 5'h00;
      end else if (persist_cnt_reg != 5'h1F) begin
        persist_cnt_reg <= persist_cnt_reg + 5'h01;
      end
    end
  end

  // A trigger in the same cycle as a clear wins, so no alarm is lost.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else if (trigger) begin
      flag_reg <= 1'b1;
    end else if (clear_stb_reg) begin
      flag_reg <= 1'b0;
    end
  end

  assign o_alarm_n_o  = 1'b0;
  assign o_alarm_n_oe = flag_reg;

endmodule : lsa_top

`default_nettype wire

// ==== testbench/lsa_host.sv ====
// Two-wire bus master model for the sensor.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module lsa_host (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_m
);
  localparam time Q = 50ns;
  initial begin
    o_scl = 1'b1;
    o_sda_m = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    o_sda_m = b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
    #Q;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, ak);
  endtask : byte_io
  task automatic start;
    o_sda_m = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_m = 1'b0;
    #Q o_scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop;
    o_sda_m = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_m = 1'b1;
    #Q;
  endtask : stop
  // Restart accesses are never sent, since this host keeps to internal timing.
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, dat, output logic nak);
    logic [7:0] rx;
    logic       a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, rx, a0);
    byte_io(ra & 8'h7F, rx, a1);
    byte_io((ra[2:0] == 3'h1) ? (dat & 8'h2F) : dat, rx, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask : wr
  task automatic rd(input logic [7:0] ra, output logic [7:0] dat, output logic nak);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start();
    byte_io({lsa_pkg::SLAVE_ADDR, 1'b0}, rx, a0);
    byte_io(ra & 8'h7F, rx, a1);
    start();
    byte_io({lsa_pkg::SLAVE_ADDR, 1'b1}, rx, a2);
    byte_io(8'hFF, dat, a3);
    stop();
    nak = a0 | a1 | a2;
  endtask : rd
endmodule : lsa_host
`default_nettype wire

// ==== testbench/lsa_properties.sv ====
// Checker on the ports of lsa_top.
// Assumes the bind at the foot reaches every lsa_top instance.
`timescale 1ns/1ps
`default_nettype none
module lsa_properties (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_scl,
  input wire logic       o_sda_o,
  input wire logic       o_sda_oe,
  input wire logic       o_alarm_n_o,
  input wire logic       o_alarm_n_oe,
  input wire logic       o_adc_core_reset,
  input wire logic       o_power_down,
  input wire logic       o_osc_fast,
  input wire logic [1:0] o_gain
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_sda; o_sda_o == 1'b0; endproperty
  a_sda: assert property (p_sda) else $error("sda driven high");
  property p_alarm; o_alarm_n_o == 1'b0; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm driven high");
  property p_osc; o_osc_fast == o_gain[1]; endproperty
  a_osc: assert property (p_osc) else $error("oscillator speed off gain");
  property p_rst; $rose(i_rst_n) |-> o_adc_core_reset && !o_power_down && !o_alarm_n_oe && o_gain == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // Bus and configuration outputs move, and the alarm only falls, while the bus clock is low, never in a high phase.
  property p_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_edge: assert property (p_edge) else $error("sda moved with clock high");
  property p_cfg; $changed({o_adc_core_reset, o_power_down, o_gain}) |-> !i_scl; endproperty
  a_cfg: assert property (p_cfg) else $error("config moved outside a write");
  property p_fall; $fell(o_alarm_n_oe) |-> !i_scl; endproperty
  a_fall: assert property (p_fall) else $error("alarm left without clear");
  property p_rise; $rose(o_alarm_n_oe) |-> !o_adc_core_reset; endproperty
  a_rise: assert property (p_rise) else $error("alarm with core off");
endmodule : lsa_properties
bind lsa_top lsa_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_alarm_n_o(o_alarm_n_o), .o_alarm_n_oe(o_alarm_n_oe), .o_adc_core_reset(o_adc_core_reset),
  .o_power_down(o_power_down), .o_osc_fast(o_osc_fast), .o_gain(o_gain));
`default_nettype wire

// ==== testbench/lsa_top_tb.sv ====
// Self-checking bench for lsa_top with a bus master model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module lsa_top_tb;
  logic       clk = 1'b0, osc = 1'b0, rst_n = 1'b0, bb = 1'b0, ir = 1'b0, bb_lvl = 1'b0, ir_lvl = 1'b0;
  logic [7:0] d;
  logic [1:0] gain;
  logic       k, scl, sda_m, sda_oe, alarm_oe, core_rst, pwr_dn;
  int         n_mismatch = 0, compares = 0;
  wire        sda = sda_m & ~sda_oe;
  always #2 clk = ~clk;
  always #24 osc = ~osc;
  always @(posedge osc) begin
    #1 bb = bb_lvl;
    ir = ir_lvl;
  end
  lsa_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_osc_clk(osc), .i_scl(scl), .i_sda_i(sda), .i_broadband_pulse(bb),
    .i_infrared_pulse(ir), .o_sda_o(), .o_sda_oe(sda_oe), .o_alarm_n_o(), .o_alarm_n_oe(alarm_oe),
    .o_adc_core_reset(core_rst), .o_power_down(pwr_dn), .o_diode_select(), .o_osc_fast(), .o_gain(gain));
  lsa_host u_host (.i_sda(sda), .o_scl(scl), .o_sda_m(sda_m));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wc(input logic [7:0] ra, dat);
    u_host.wr(lsa_pkg::SLAVE_ADDR, ra, dat, k);
    chk({7'h0, k}, 8'h00);
  endtask : wc
  task automatic rc(input logic [7:0] ra, exp);
    u_host.rd(ra, d, k);
    chk(d, exp);
    chk({7'h0, k}, 8'h00);
  endtask : rc
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // The oscillator domain needs its own synced reset, so reset spans several oscillator cycles.
  initial begin
    repeat (50) @(posedge clk);
    #1 rst_n = 1'b1;
    #40;
    rc(8'h02, 8'hFF);
    rc(8'h03, 8'h00);
    chk({6'h0, core_rst, pwr_dn}, 8'h02);
    wc(8'h00, 8'h40);
    chk({6'h0, core_rst, pwr_dn}, 8'h03);
    wc(8'h01, 8'h0C);
    chk({6'h0, gain}, 8'h03);
    rc(8'h00, 8'h40);
    wc(8'h04, 8'h55);
    rc(8'h04, 8'h00);
    u_host.wr(7'h45, 8'h00, 8'h83, k);
    chk({6'h0, k, core_rst}, 8'h03);
    bb_lvl = 1'b1;
    wc(8'h00, 8'h83);
    #5000;
    rc(8'h04, 8'h0F);
    rc(8'h05, 8'h00);
    rc(8'h06, 8'h10);
    chk({7'h0, alarm_oe}, 8'h00);
    bb_lvl = 1'b0;
    ir_lvl = 1'b1;
    wc(8'h00, 8'h8B);
    #5000;
    rc(8'h04, 8'hF1);
    rc(8'h05, 8'hFF);
    rc(8'h01, 8'h2C);
    chk({7'h0, alarm_oe}, 8'h01);
    wc(8'h00, 8'h00);
    #3000;
    chk({7'h0, alarm_oe}, 8'h01);
    wc(8'h41, 8'h0C);
    chk({7'h0, alarm_oe}, 8'h00);
    rc(8'h01, 8'h0C);
    // Persistence of four: one difference result fits before the first look, four before the second.
    wc(8'h01, 8'h0D);
    wc(8'h00, 8'h8B);
    #2500 chk({7'h0, alarm_oe}, 8'h00);
    #5000 chk({7'h0, alarm_oe}, 8'h01);
    tally_and_finish();
  end
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : lsa_top_tb
`default_nettype wire
